// ### rtl/vrts_ctrl.sv
// axi4-lite control register bank for voltage reference and temperature sense
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`include "vrts_defines.svh"
// How it works
// - bit 7 turns the reference on
// - bit 6 read-only ready flag
// - standard variant reads ready always one
// - bit 5 enables temperature sensor
// - bit 4 selects high or low range
// - bits 3-2 comparator/DAC gain decode
// - bits 1-0 ADC gain decode
// - writable control bits clear on every reset; the stabilization count reloads its default
// - sensor output routed to dedicated ADC channel
module vrts_ctrl
   import vrts_pkg::*;
#(
   parameter logic STD_VARIANT = 1'b0
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             ref_enable,
   output logic             temp_sense_enable,
   output logic             temp_range_select,
   output logic [2:0]       cmp_dac_gain_sel,
   output logic [2:0]       adc_gain_sel,
   output logic             temp_adc_chan_route
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]             ctrl;
   logic [`VRTS_CNT_W-1:0] stab_cycles;
   logic                   aw_held;
   logic                   w_held;
   logic [7:0]             aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic                   timer_ready;
   logic                   ref_ready;
   logic                   do_write;
   logic [7:0]             next_ctrl;

   // one-hot gain select: x1, x2, x4; all zero means buffer off
   function automatic logic [2:0] gain_decode(input logic [1:0] code);
      case (code)
         `VRTS_GAIN_X4: gain_decode = 3'h4;
         `VRTS_GAIN_X2: gain_decode = 3'h2;
         `VRTS_GAIN_X1: gain_decode = 3'h1;
         default:       gain_decode = 3'h0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // stabilization timer
   // ------------------------------------------------------------
   vrts_stab_timer u_timer (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .clk_en        (clk_en),
      .enable        (ctrl[`VRTS_BIT_REF_EN]),
      .settle_cycles (stab_cycles),
      .ready         (timer_ready)
   );

   assign ref_ready = STD_VARIANT ? 1'b1 : timer_ready;

   // ------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         s_axi_awready <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         w_held       <= 1'b0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_wready <= 1'b0;
      end else if (clk_en) begin
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VRTS_RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == `VRTS_ADDR_CTRL || aw_addr == `VRTS_ADDR_STAB)
                            ? `VRTS_RESP_OKAY : `VRTS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // ready bit is masked off: writes to it have no effect
   always_comb begin
      next_ctrl = ctrl;
      if (do_write && aw_addr == `VRTS_ADDR_CTRL && w_strb[0]) begin
         next_ctrl = (w_data[7:0] & `VRTS_WR_MASK) | (ctrl & ~`VRTS_WR_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl <= `VRTS_CTRL_RST;
      end else if (clk_en) begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stab_cycles <= `VRTS_CNT_W'(`VRTS_STAB_CYC);
      end else if (clk_en && do_write && aw_addr == `VRTS_ADDR_STAB) begin
         if (w_strb[0]) begin
            stab_cycles[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            stab_cycles[15:8] <= w_data[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `VRTS_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `VRTS_RESP_OKAY;
            case (s_axi_araddr)
               `VRTS_ADDR_CTRL: begin
                  s_axi_rdata <= {24'h0, ctrl[`VRTS_BIT_REF_EN], ref_ready, ctrl[`VRTS_BIT_TS_EN:0]};
               end
               `VRTS_ADDR_STAB: s_axi_rdata <= {16'h0, stab_cycles};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= `VRTS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // analog controls, registered from the next control value
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ref_enable          <= 1'b0;
         temp_sense_enable   <= 1'b0;
         temp_range_select   <= 1'b0;
         cmp_dac_gain_sel    <= 3'h0;
         adc_gain_sel        <= 3'h0;
         temp_adc_chan_route <= 1'b0;
      end else if (clk_en) begin
         ref_enable          <= next_ctrl[`VRTS_BIT_REF_EN];
         temp_sense_enable   <= next_ctrl[`VRTS_BIT_TS_EN];
         temp_range_select   <= next_ctrl[`VRTS_BIT_TS_RNG];
         cmp_dac_gain_sel    <= gain_decode(next_ctrl[`VRTS_CDG_HI:`VRTS_CDG_LO]);
         adc_gain_sel        <= gain_decode(next_ctrl[`VRTS_ADG_HI:`VRTS_ADG_LO]);
         // sensor feeds its reserved adc channel only while it is powered
         temp_adc_chan_route <= next_ctrl[`VRTS_BIT_TS_EN];
      end
   end
endmodule

// ### common/vrts_defines.svh
// constants for the voltage reference and temperature sense control block
`ifndef VRTS_DEFINES_SVH
`define VRTS_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define VRTS_ADDR_CTRL     8'h00
`define VRTS_ADDR_STAB     8'h04
`define VRTS_ADDR_W        8

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define VRTS_BIT_REF_EN    7
`define VRTS_BIT_READY     6
`define VRTS_BIT_TS_EN     5
`define VRTS_BIT_TS_RNG    4
`define VRTS_CDG_HI        3
`define VRTS_CDG_LO        2
`define VRTS_ADG_HI        1
`define VRTS_ADG_LO        0
`define VRTS_CTRL_RST      8'h00
`define VRTS_WR_MASK       8'hbf

// ----------------------------------------------------------------
// gain codes
// ----------------------------------------------------------------
`define VRTS_GAIN_OFF      2'h0
`define VRTS_GAIN_X1       2'h1
`define VRTS_GAIN_X2       2'h2
`define VRTS_GAIN_X4       2'h3

// ----------------------------------------------------------------
// stabilization timing
// ----------------------------------------------------------------
`define VRTS_CLK_MHZ       250
`define VRTS_STAB_US       25
`define VRTS_STAB_CYC      (`VRTS_STAB_US * `VRTS_CLK_MHZ)
`define VRTS_CNT_W         16

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define VRTS_RESP_OKAY     2'h0
`define VRTS_RESP_SLVERR   2'h2

`endif

// ### common/vrts_pkg.sv
// types for the voltage reference and temperature sense control block
package vrts_pkg;
   typedef enum logic [1:0] {
      VRTS_REF_OFF    = 2'b00,
      VRTS_REF_SETTLE = 2'b01,
      VRTS_REF_READY  = 2'b10
   } vrts_ref_state_e;
endpackage

// ### rtl/vrts_stab_timer.sv
// stabilization timer for the reference ready flag
`include "vrts_defines.svh"
module vrts_stab_timer
   import vrts_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic                   clk_en,
   input  wire logic                   enable,
   input  wire logic [`VRTS_CNT_W-1:0] settle_cycles,
   output logic                        ready
);
   vrts_ref_state_e        state;
   logic [`VRTS_CNT_W-1:0] count;

   // ------------------------------------------------------------
   // settle sequence
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= VRTS_REF_OFF;
         count <= '0;
      end else if (clk_en) begin
         if (!enable) begin
            state <= VRTS_REF_OFF;
            count <= '0;
         end else begin
            case (state)
               VRTS_REF_OFF: begin
                  state <= VRTS_REF_SETTLE;
                  count <= '0;
               end
               VRTS_REF_SETTLE: begin
                  if (count >= settle_cycles) begin
                     state <= VRTS_REF_READY;
                  end else begin
                     count <= count + 1'b1;
                  end
               end
               VRTS_REF_READY: state <= VRTS_REF_READY;
               default: state <= VRTS_REF_OFF;
            endcase
         end
      end
   end

   // drops in the same cycle the enable falls, so no stale ready is seen
   assign ready = enable && (state == VRTS_REF_READY);
endmodule

// ### tb/vrts_ctrl_props.sv
// assertion checker for the reference control bank
`include "vrts_defines.svh"
module vrts_ctrl_props #(
   parameter logic STD_VARIANT = 1'b0
) (
   input logic        sys_clk,
   input logic        rst_n,
   input logic        clk_en,
   input logic [7:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0]  s_axi_wstrb,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic [7:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        ref_enable,
   input logic        temp_sense_enable,
   input logic [2:0]  cmp_dac_gain_sel,
   input logic [2:0]  adc_gain_sel,
   input logic        temp_adc_chan_route
);
   logic [7:0] aw_q, ar_q, w_q;
   logic       ws_q, rd_ctrl, aw_map, ar_map;
   // ------------------------------
   // captured request fields
   // ------------------------------
   always_ff @(posedge sys_clk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
   end
   assign rd_ctrl = s_axi_rvalid && ar_q == `VRTS_ADDR_CTRL;
   assign aw_map  = aw_q == `VRTS_ADDR_CTRL || aw_q == `VRTS_ADDR_STAB;
   assign ar_map  = ar_q == `VRTS_ADDR_CTRL || ar_q == `VRTS_ADDR_STAB;
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   rd_field_a: assert property (rd_ctrl |-> s_axi_rdata[7] == ref_enable &&
      s_axi_rdata[5] == temp_sense_enable && s_axi_rdata[31:8] == 24'h0) else $error("ctrl read mismatch");
   rd_gain_a: assert property (rd_ctrl |-> {1'b0, cmp_dac_gain_sel} == (4'h1 << s_axi_rdata[3:2]) >> 1 &&
      {1'b0, adc_gain_sel} == (4'h1 << s_axi_rdata[1:0]) >> 1) else $error("gain decode mismatch");
   rd_ready_a: assert property (rd_ctrl |-> (STD_VARIANT ? s_axi_rdata[6] : (!s_axi_rdata[6] || ref_enable)))
      else $error("ready flag wrong");
   route_a: assert property (temp_adc_chan_route == temp_sense_enable) else $error("sensor route wrong");
   bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rlat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   wresp_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (aw_map ? `VRTS_RESP_OKAY : `VRTS_RESP_SLVERR))
      else $error("write response code wrong");
   rresp_a: assert property ($rose(s_axi_rvalid) |-> (ar_map ? s_axi_rresp == `VRTS_RESP_OKAY :
      s_axi_rresp == `VRTS_RESP_SLVERR && s_axi_rdata == 32'h0)) else $error("read response code wrong");
   wr_out_a: assert property ($rose(s_axi_bvalid) && aw_q == `VRTS_ADDR_CTRL && ws_q |->
      ref_enable == w_q[7] && temp_sense_enable == w_q[5]) else $error("outputs not updated by write");
   freeze_hold_a: assert property (!clk_en |=> $stable({ref_enable, temp_sense_enable, cmp_dac_gain_sel,
      adc_gain_sel, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid}))
      else $error("state moved while frozen");
   cover property (!clk_en && ref_enable);
   cover property (rd_ctrl && s_axi_rdata[6]);
   cover property ($rose(s_axi_bvalid) && s_axi_bresp == `VRTS_RESP_SLVERR);
   cover property (rd_ctrl && s_axi_rdata[3:2] == 2'h3);
endmodule

bind vrts_ctrl vrts_ctrl_props #(.STD_VARIANT(STD_VARIANT)) i_props (.*);

// ### tb/vrts_ctrl_tb.sv
// self-checking bench for the reference control bank
`include "vrts_defines.svh"
module vrts_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] a_ctrl = `VRTS_ADDR_CTRL;
   localparam logic [7:0] a_stab = `VRTS_ADDR_STAB;
   localparam logic [1:0] r_ok = `VRTS_RESP_OKAY;
   localparam logic [1:0] r_err = `VRTS_RESP_SLVERR;
   logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, std_rdata, sd;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        ref_enable, temp_sense_enable, temp_range_select, temp_adc_chan_route;
   logic [2:0]  cmp_dac_gain_sel, adc_gain_sel;
   int          num_errors = 0, check_count = 0;
   vrts_ctrl i_dut (.*);
   // standard variant judged here only on its whole control read word (ready and reference bits); the bound checker also covers it
   vrts_ctrl #(.STD_VARIANT(1'b1)) i_std (.*, .s_axi_rdata(std_rdata), .s_axi_awready(), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rresp(), .s_axi_rvalid(), .ref_enable(),
      .temp_sense_enable(), .temp_range_select(), .cmp_dac_gain_sel(), .adc_gain_sel(), .temp_adc_chan_route());
   initial forever #2 sys_clk = ~sys_clk;
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [2:0] oh(input logic [1:0] c);
      return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
   endfunction
   function automatic logic [31:0] outs();
      return 32'({ref_enable, temp_sense_enable, temp_range_select, temp_adc_chan_route, cmp_dac_gain_sel,
         adc_gain_sel});
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ad = 1'b0;
      logic wd = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge sys_clk);
         if (s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (!s_axi_bvalid);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      sd = std_rdata;
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      s_axi_rready <= 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset;
      logic [31:0] d;
      rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk("reset outputs", 32'h0, outs());
      rd(a_ctrl, d, r_ok);
      chk("reset ctrl", 32'h0, d);
      rd(a_stab, d, r_ok);
      chk("reset stab", 32'(`VRTS_STAB_CYC), d);
   endtask
   task automatic t_fields;
      logic [31:0] d;
      logic [7:0]  v;
      for (int i = 0; i < 4; i++) begin
         // bit 6 set to prove that software cannot force ready
         v = {2'b01, i[0], i[1], i[1:0], ~i[1:0]};
         wr(a_ctrl, {24'h0, v}, 4'h1, r_ok);
         chk("outputs", 32'({1'b0, i[0], i[1], i[0], oh(i[1:0]), oh(~i[1:0])}), outs());
         rd(a_ctrl, d, r_ok);
         chk("ctrl", {24'h0, v & 8'hbf}, d);
      end
   endtask
   task automatic t_ready;
      logic [31:0] d;
      wr(a_stab, 32'd40, 4'h3, r_ok);
      rd(a_stab, d, r_ok);
      chk("stab", 32'd40, d);
      wr(a_ctrl, 32'h80, 4'h1, r_ok);
      chk("ref on", 32'h200, outs());
      rd(a_ctrl, d, r_ok);
      chk("settling", 32'h80, d);
      chk("std ready", 32'hc0, sd);
      // timer must not advance while the enable is low
      clk_en <= 1'b0;
      repeat (60) @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(a_ctrl, d, r_ok);
      chk("frozen", 32'h80, d);
      repeat (50) @(posedge sys_clk);
      rd(a_ctrl, d, r_ok);
      chk("ready", 32'hc0, d);
      wr(a_ctrl, 32'h0, 4'h1, r_ok);
      chk("ref off", 32'h0, outs());
      rd(a_ctrl, d, r_ok);
      chk("ready off", 32'h0, d);
      chk("std off", 32'h40, sd);
   endtask
   task automatic t_bad;
      logic [31:0] d;
      wr(8'h08, 32'hff, 4'hf, r_err);
      wr(a_ctrl, 32'hff, 4'he, r_ok);
      rd(8'h08, d, r_err);
      chk("unmapped", 32'h0, d);
      rd(a_ctrl, d, r_ok);
      chk("kept", 32'h0, d);
   endtask
   initial begin
      t_reset;
      // no conversion is started and no buffered reference is used, so no wait is owed
      t_fields;
      t_ready;
      t_bad;
      wr(a_ctrl, 32'hbf, 4'h1, r_ok);
      t_reset;
      end_sim;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      end_sim;
   end
endmodule
